// ### move_datapath.sv
// Full word, half word, byte, exchange and block copy datapath
// What this block does
// - Full moves: plain, swapped, negated, magnitude
// - Basic loads accumulator, memory mode stores it
// - Immediate mode moves the effective address itself
// - Self mode transforms word in place
// - Source word untouched except in self mode
// - Sixteen half moves: source, destination, treatment
// - Other half kept, zeroed, ones or sign
// - Sign fill uses moved half's top bit
// - Half self mode rewrites word in place
// - Byte sits in bits 36-P-S to 35-P
// - Byte word address via normal address calculation
// - Advance: P-S, wrap bumps address, P=36-S
// - Load byte right justified, upper bits cleared
// - Deposit low S accumulator bits into byte
// - Advancing variants step pointer before access
// - Exchange swaps accumulator and memory word
// - Block copy from left half to right half
// - Block copy ends after writing effective address
// - Accumulator read once, saved on interrupt
// - Two's complement, carries out dropped, bit0 sign
// - Float negation is whole word complement
// - Float: sign, 8 bit exponent, 27 bit fraction
// - Address plus index, indirect repeats calculation
// - Accumulators and index registers are low memory
`timescale 1ns/1ps
`default_nettype none

module move_datapath
  import move_pkg::*;
(
  input  wire logic        core_clk,        // 10 MHz clock
  input  wire logic        resetn,          // Asynchronous reset
  input  wire logic        start,           // Begin instruction
  input  wire instr_t      instr,           // Decoded instruction
  input  wire logic        irq_req,         // Interrupt wants a break
  input  wire logic        mem_ack,         // Memory access completed
  input  wire logic [35:0] mem_rdata,       // Memory read data
  output var  mem_cmd_t    mem_cmd,         // Memory command
  output logic             busy,            // Instruction in progress
  output logic             done,            // Instruction finished
  output logic             blt_interrupted, // Block copy was broken off
  output logic [7:0]       res_exponent     // Exponent of last result
);

  // ********************
  // State encoding
  // ********************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_EA  = 4'h1, ST_IDX = 4'h3, ST_IND = 4'h2,
    ST_PTR  = 4'h6, ST_PWR = 4'h7, ST_RDM = 4'h5, ST_RDA = 4'h4,
    ST_CALC = 4'hC, ST_WRM = 4'hD, ST_WRA = 4'hF, ST_BRD = 4'hE,
    ST_BWR  = 4'hA, ST_BSAV = 4'hB, ST_DONE = 4'h9
  } state_t;

  state_t      state_q, state_d;   // Sequencer
  instr_t      ins_q, ins_d;       // Latched instruction
  logic [17:0] ea_q, ea_d;         // Address under calculation
  logic [3:0]  xr_q, xr_d;         // Pending index register
  logic        ind_q, ind_d;       // Pending indirection
  logic        bp_q, bp_d;         // Resolving the byte word address
  logic [35:0] ptr_q, ptr_d;       // Byte pointer
  logic [35:0] mq_q, mq_d;         // Memory operand
  logic [35:0] acv_q, acv_d;       // Accumulator operand
  logic [35:0] res_q, res_d;       // Result
  logic [17:0] src_q, src_d;       // Block copy source
  logic [17:0] dst_q, dst_d;       // Block copy destination
  logic        intr_q, intr_d;     // Block copy interrupted
  mem_cmd_t    cmd_q, cmd_d;       // Memory command
  logic [17:0] ac_addr;            // Accumulator address

  // ********************
  // Helper functions
  // ********************
  // Builds a memory command
  function automatic mem_cmd_t access(input logic we,
                                      input logic [17:0] a,
                                      input logic [35:0] d);
    access = '{req: 1'b1, we: we, addr: a, wdata: d};
  endfunction

  // Two's complement, carry out of the top bit dropped
  function automatic logic [35:0] negate(input logic [35:0] w);
    negate = ~w + 36'h1;
  endfunction

  // Ones in the low s bits
  function automatic logic [35:0] low_mask(input logic [5:0] s);
    low_mask = ~(36'hF_FFFF_FFFF << s);
  endfunction

  // Steps a pointer one byte to the right
  function automatic logic [35:0] advance(input logic [35:0] p);
    logic [5:0] pos;
    logic [5:0] sz;
    pos = p[P_MSB:P_LSB];
    sz = p[S_MSB:S_LSB];
    advance = p;
    if (pos < sz) begin
      advance[17:0] = p[17:0] + 18'h1;
      advance[P_MSB:P_LSB] = WORD_LEN - sz;
    end else begin
      advance[P_MSB:P_LSB] = pos - sz;
    end
  endfunction

  // Full and half word move result
  function automatic logic [35:0] move_result(input instr_t i,
                                              input logic [35:0] m,
                                              input logic [35:0] a);
    logic [35:0] src;
    logic [35:0] old;
    logic [17:0] h;
    logic [17:0] oth;
    // Memory mode moves the accumulator, immediate the address, others the memory word
    src = (i.mode == MD_MEMORY) ? a : m;
    // Destination is the accumulator in basic and immediate mode
    old = (i.mode == MD_MEMORY || i.mode == MD_SELF) ? m : a;
    h = i.src_left ? src[35:18] : src[17:0];
    oth = i.dst_left ? old[17:0] : old[35:18];
    move_result = src;
    if (i.op == OP_MOVE) begin
      case (i.xform)
        XF_HALVES_SWAPPED: move_result = {src[17:0], src[35:18]};
        XF_NEGATED:        move_result = negate(src);
        XF_MAGNITUDE:      move_result = src[35] ? negate(src) : src;
        default:           move_result = src;
      endcase
    end else begin
      case (i.fill)
        FILL_ZERO: oth = 18'h0_0000;
        FILL_ONES: oth = 18'h3_FFFF;
        FILL_SIGN: oth = {18{h[17]}};
        default:   oth = oth;
      endcase
      move_result = i.dst_left ? {h, oth} : {oth, h};
    end
  endfunction

  // ********************
  // Decoded properties of the latched instruction
  // ********************
  logic is_move;     // Full or half move
  logic is_byte;     // Any byte operation
  logic is_adv;      // Pointer stepped first
  logic is_dep;      // Deposit variants
  logic needs_ac;    // Accumulator operand read
  logic writes_mem;  // Result goes to memory
  logic [5:0] bpos;  // Byte position
  logic [5:0] bsz;   // Byte size

  always_comb begin
    is_move = (ins_q.op == OP_MOVE) || (ins_q.op == OP_HALF);
    is_adv = (ins_q.op == OP_ADVANCE_PTR) ||
             (ins_q.op == OP_ADV_LOAD_BYTE) ||
             (ins_q.op == OP_ADV_DEPOSIT_BYTE);
    is_dep = (ins_q.op == OP_DEPOSIT_BYTE) ||
             (ins_q.op == OP_ADV_DEPOSIT_BYTE);
    is_byte = is_adv || is_dep || (ins_q.op == OP_LOAD_BYTE);
    // Self mode reads only the memory word
    needs_ac = (is_move && ins_q.mode != MD_SELF) || is_dep ||
               (ins_q.op == OP_SWAP_AC_MEM);
    writes_mem = (is_move && (ins_q.mode == MD_MEMORY ||
                              ins_q.mode == MD_SELF)) || is_dep ||
                 (ins_q.op == OP_SWAP_AC_MEM);
    bpos = ptr_q[P_MSB:P_LSB];
    bsz = ptr_q[S_MSB:S_LSB];
  end

  assign ac_addr = {AC_HI, ins_q.ac};

  // ********************
  // Sequencer next state
  // ********************
  always_comb begin
    state_d = state_q;
    ins_d = ins_q;
    ea_d = ea_q;
    xr_d = xr_q;
    ind_d = ind_q;
    bp_d = bp_q;
    ptr_d = ptr_q;
    mq_d = mq_q;
    acv_d = acv_q;
    res_d = res_q;
    src_d = src_q;
    dst_d = dst_q;
    intr_d = intr_q;
    cmd_d = cmd_q;
    // Command drops once memory answers
    if (mem_ack) begin
      cmd_d.req = 1'b0;
    end
    case (state_q)
      // Wait for an instruction
      ST_IDLE: begin
        if (start) begin
          ins_d = instr;
          ea_d = instr.addr_word[17:0];
          xr_d = instr.addr_word[X_MSB:X_LSB];
          ind_d = instr.addr_word[IND_BIT];
          bp_d = 1'b0;
          intr_d = 1'b0;
          state_d = ST_EA;
        end
      end
      // Address calculation step
      ST_EA: begin
        if (xr_q != 4'h0) begin
          cmd_d = access(1'b0, {AC_HI, xr_q}, 36'h0);
          state_d = ST_IDX;
        end else if (ind_q) begin
          cmd_d = access(1'b0, ea_q, 36'h0);
          state_d = ST_IND;
        end else if (is_byte && !bp_q) begin
          cmd_d = access(1'b0, ea_q, 36'h0);
          state_d = ST_PTR;
        end else if (ins_q.op == OP_BLOCK_COPY) begin
          cmd_d = access(1'b0, ac_addr, 36'h0);
          state_d = ST_RDA;
        end else if (is_move && ins_q.mode == MD_IMMEDIATE) begin
          mq_d = {18'h0_0000, ea_q};
          cmd_d = access(1'b0, ac_addr, 36'h0);
          state_d = ST_RDA;
        end else begin
          cmd_d = access(1'b0, ea_q, 36'h0);
          state_d = ST_RDM;
        end
      end
      // Index register right half added, carry dropped
      ST_IDX: begin
        if (mem_ack) begin
          ea_d = ea_q + mem_rdata[17:0];
          xr_d = 4'h0;
          state_d = ST_EA;
        end
      end
      // Indirect word restarts the calculation
      ST_IND: begin
        if (mem_ack) begin
          ea_d = mem_rdata[17:0];
          xr_d = mem_rdata[X_MSB:X_LSB];
          ind_d = mem_rdata[IND_BIT];
          state_d = ST_EA;
        end
      end
      // Pointer fetched
      ST_PTR: begin
        if (mem_ack) begin
          if (is_adv) begin
            ptr_d = advance(mem_rdata);
            cmd_d = access(1'b1, ea_q, advance(mem_rdata));
            state_d = ST_PWR;
          end else begin
            ptr_d = mem_rdata;
            ea_d = mem_rdata[17:0];
            xr_d = mem_rdata[X_MSB:X_LSB];
            ind_d = mem_rdata[IND_BIT];
            bp_d = 1'b1;
            state_d = ST_EA;
          end
        end
      end
      // Advanced pointer written back
      ST_PWR: begin
        if (mem_ack) begin
          if (ins_q.op == OP_ADVANCE_PTR) begin
            state_d = ST_DONE;
          end else begin
            ea_d = ptr_q[17:0];
            xr_d = ptr_q[X_MSB:X_LSB];
            ind_d = ptr_q[IND_BIT];
            bp_d = 1'b1;
            state_d = ST_EA;
          end
        end
      end
      // Memory operand
      ST_RDM: begin
        if (mem_ack) begin
          mq_d = mem_rdata;
          if (needs_ac) begin
            cmd_d = access(1'b0, ac_addr, 36'h0);
            state_d = ST_RDA;
          end else begin
            state_d = ST_CALC;
          end
        end
      end
      // Accumulator operand
      ST_RDA: begin
        if (mem_ack) begin
          acv_d = mem_rdata;
          if (ins_q.op == OP_BLOCK_COPY) begin
            src_d = mem_rdata[35:18];
            dst_d = mem_rdata[17:0];
            cmd_d = access(1'b0, mem_rdata[35:18], 36'h0);
            state_d = ST_BRD;
          end else begin
            state_d = ST_CALC;
          end
        end
      end
      // Form the result and pick its destination
      ST_CALC: begin
        if (ins_q.op == OP_SWAP_AC_MEM) begin
          res_d = acv_q;
        end else if (is_dep) begin
          res_d = (mq_q & ~(low_mask(bsz) << bpos)) |
                  ((acv_q & low_mask(bsz)) << bpos);
        end else if (is_byte) begin
          res_d = (mq_q >> bpos) & low_mask(bsz);
        end else begin
          res_d = move_result(ins_q, mq_q, acv_q);
        end
        if (writes_mem) begin
          cmd_d = access(1'b1, ea_q, res_d);
          state_d = ST_WRM;
        end else begin
          cmd_d = access(1'b1, ac_addr, res_d);
          state_d = ST_WRA;
        end
      end
      // Memory write; exchange then writes the accumulator
      ST_WRM: begin
        if (mem_ack) begin
          if (ins_q.op == OP_SWAP_AC_MEM) begin
            cmd_d = access(1'b1, ac_addr, mq_q);
            state_d = ST_WRA;
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      // Accumulator write
      ST_WRA: begin
        if (mem_ack) begin
          state_d = ST_DONE;
        end
      end
      // Block copy read of one source word
      ST_BRD: begin
        if (mem_ack) begin
          mq_d = mem_rdata;
          cmd_d = access(1'b1, dst_q, mem_rdata);
          state_d = ST_BWR;
        end
      end
      // Block copy write; last when it hits the address
      ST_BWR: begin
        if (mem_ack) begin
          src_d = src_q + 18'h1;
          dst_d = dst_q + 18'h1;
          if (dst_q == ea_q) begin
            state_d = ST_DONE;
          end else if (irq_req) begin
            cmd_d = access(1'b1, ac_addr,
                           {src_q + 18'h1, dst_q + 18'h1});
            state_d = ST_BSAV;
          end else begin
            cmd_d = access(1'b0, src_q + 18'h1, 36'h0);
            state_d = ST_BRD;
          end
        end
      end
      // Progress saved for resumption
      ST_BSAV: begin
        if (mem_ack) begin
          intr_d = 1'b1;
          state_d = ST_DONE;
        end
      end
      // One cycle of completion
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ********************
  // Registers
  // ********************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      ins_q <= '0;
      ea_q <= '0;
      xr_q <= '0;
      ind_q <= 1'b0;
      bp_q <= 1'b0;
      ptr_q <= '0;
      mq_q <= '0;
      acv_q <= '0;
      res_q <= '0;
      src_q <= '0;
      dst_q <= '0;
      intr_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      state_q <= state_d;
      ins_q <= ins_d;
      ea_q <= ea_d;
      xr_q <= xr_d;
      ind_q <= ind_d;
      bp_q <= bp_d;
      ptr_q <= ptr_d;
      mq_q <= mq_d;
      acv_q <= acv_d;
      res_q <= res_d;
      src_q <= src_d;
      dst_q <= dst_d;
      intr_q <= intr_d;
      cmd_q <= cmd_d;
    end
  end

  // ********************
  // Outputs
  // ********************
  assign mem_cmd = cmd_q;
  assign busy = (state_q != ST_IDLE);
  assign done = (state_q == ST_DONE);
  assign blt_interrupted = intr_q;
  assign res_exponent = res_q[FPE_MSB:FPE_LSB];

endmodule

`default_nettype wire

// ### move_pkg.sv
// Constants, enumerations and carrier types of the word move datapath
package move_pkg;

  // ********************
  // Word geometry (vector bit 35 is word bit 0, the sign)
  // ********************
  localparam int          WORD_W   = 36;      // Word width
  localparam int          ADDR_W   = 18;      // Address width
  localparam logic [5:0]  WORD_LEN = 6'h24;   // 36 as a position count
  localparam int          IND_BIT  = 22;      // Indirect flag, word bit 13
  localparam int          X_MSB    = 21;      // Index field, word bits 14-17
  localparam int          X_LSB    = 18;
  localparam int          EAW_MSB  = 22;      // Address word, bits 13-35
  localparam int          P_MSB    = 35;      // Position field, bits 0-5
  localparam int          P_LSB    = 30;
  localparam int          S_MSB    = 29;      // Size field, bits 6-11
  localparam int          S_LSB    = 24;
  localparam int          FPE_MSB  = 34;      // Exponent, word bits 1-8
  localparam int          FPE_LSB  = 27;      // Fraction starts at bit 9
  localparam logic [13:0] AC_HI    = 14'h0000; // Accumulators live at 0-15

  // ********************
  // Instruction encodings
  // ********************
  typedef enum logic [3:0] {
    OP_MOVE, OP_HALF, OP_LOAD_BYTE, OP_DEPOSIT_BYTE, OP_ADVANCE_PTR,
    OP_ADV_LOAD_BYTE, OP_ADV_DEPOSIT_BYTE, OP_SWAP_AC_MEM, OP_BLOCK_COPY
  } op_t;

  typedef enum logic [1:0] {
    XF_PLAIN, XF_HALVES_SWAPPED, XF_NEGATED, XF_MAGNITUDE
  } xform_t;

  typedef enum logic [1:0] {
    MD_BASIC, MD_IMMEDIATE, MD_MEMORY, MD_SELF
  } mode_t;

  typedef enum logic [1:0] {
    FILL_KEEP, FILL_ZERO, FILL_ONES, FILL_SIGN
  } fill_t;

  // Decoded instruction handed over by the decoder
  typedef struct packed {
    op_t         op;        // Operation
    xform_t      xform;     // Full word transform
    mode_t       mode;      // Transmission mode
    logic        src_left;  // Half move takes the left half
    logic        dst_left;  // Half move lands in the left half
    fill_t       fill;      // Treatment of the other half
    logic [3:0]  ac;        // Accumulator number
    logic [22:0] addr_word; // Indirect, index and address fields
  } instr_t;

  // Memory bus command
  typedef struct packed {
    logic        req;   // Access pending
    logic        we;    // Write
    logic [17:0] addr;  // Word address
    logic [35:0] wdata; // Write data
  } mem_cmd_t;

endpackage

// ### move_datapath_properties.sv
// Port-level checker for the word move datapath
`timescale 1ns/1ps
`default_nettype none

module move_checker
  import move_pkg::*;
(
  input wire logic     core_clk,       // Clock
  input wire logic     resetn,         // Reset, active low
  input wire logic     start,          // Start request
  input wire instr_t   instr,          // Decoded instruction
  input wire logic     mem_ack,        // Access completed
  input wire mem_cmd_t mem_cmd,        // Memory command
  input wire logic     busy,           // Instruction running
  input wire logic     done,           // End pulse
  input wire logic     blt_interrupted // Block copy broke off
);
  // ********************
  // Helper state
  // ********************
  instr_t      ins_q, ins_d;   // Instruction in flight
  logic        have_q, have_d; // A block word was written
  logic [17:0] nxt_q, nxt_d;   // Next block destination
  logic        blk;            // Block copy running
  logic        acc;            // Command aims at the accumulator
  assign blk = busy && ins_q.op == OP_BLOCK_COPY;
  assign acc = mem_cmd.addr == {14'h0000, ins_q.ac};
  // Next values: latch at start, track block destinations
  always_comb begin
    ins_d  = ins_q;
    have_d = have_q;
    nxt_d  = nxt_q;
    if (start && !busy) begin
      ins_d  = instr;
      have_d = 1'b0;
    end else if (blk && mem_ack && mem_cmd.we && !acc) begin
      have_d = 1'b1;
      nxt_d  = mem_cmd.addr + 18'h00001;
    end
  end
  // Register the helper state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ins_q  <= '0;
      have_q <= 1'b0;
      nxt_q  <= 18'h00000;
    end else begin
      ins_q  <= ins_d;
      have_q <= have_d;
      nxt_q  <= nxt_d;
    end
  end
  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  cmd_hold_a: assert property (mem_cmd.req && !mem_ack |=>
    mem_cmd.req && $stable(mem_cmd))
    else $error("command moved");
  req_busy_a: assert property (mem_cmd.req |-> busy)
    else $error("access while idle");
  done_pulse_a: assert property (done |-> busy ##1 !done)
    else $error("done too long");
  imm_first_a: assert property (start && !busy && instr.op == OP_MOVE
    && instr.mode == MD_IMMEDIATE && instr.addr_word[22:18] == 5'h00
    |-> ##[1:6] mem_cmd.req && !mem_cmd.we && acc)
    else $error("no ac read");
  blt_last_a: assert property (blk && mem_cmd.req && mem_cmd.we && !acc
    |-> mem_cmd.addr <= ins_q.addr_word[17:0])
    else $error("copy past end");
  blt_order_a: assert property (blk && mem_cmd.req && mem_cmd.we
    && !acc && have_q |-> mem_cmd.addr == nxt_q)
    else $error("copy out of order");
  blt_save_a: assert property (blk && mem_ack && mem_cmd.we && acc
    |-> ##[1:3] blt_interrupted)
    else $error("break unflagged");
  flag_clear_a: assert property (start && !busy |-> ##2 !blt_interrupted)
    else $error("break flag kept");
endmodule

bind move_datapath move_checker i_chk (
  .core_clk(core_clk), .resetn(resetn), .start(start), .instr(instr),
  .mem_ack(mem_ack), .mem_cmd(mem_cmd), .busy(busy), .done(done),
  .blt_interrupted(blt_interrupted));
`default_nettype wire

// ### move_memory_model.sv
// Behavioural memory answering the datapath's bus
`timescale 1ns/1ps
`default_nettype none

module move_memory_model
  import move_pkg::*;
(
  input  wire logic       core_clk,    // Clock
  input  wire logic       resetn,      // Reset, active low
  input  wire mem_cmd_t   mem_cmd,     // Command from the datapath
  input  wire logic [1:0] wait_cycles, // Extra cycles before each ack
  output logic            mem_ack,     // Completion pulse
  output logic [35:0]     mem_rdata    // Read data, valid with ack
);
  logic [35:0] mem [256]; // Word store, accumulators at 0-15
  logic [1:0]  cnt_q;     // Remaining wait cycles
  // One access at a time; data shows junk outside the ack cycle
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 36'hA5A5A5A5A;
      cnt_q     <= 2'h0;
    end else if (mem_ack || !mem_cmd.req) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt_q     <= wait_cycles;
    end else if (cnt_q != 2'h0) begin
      cnt_q     <= cnt_q - 2'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      // Plain low memory serves as accumulator too
      if (mem_cmd.we) begin
        mem[mem_cmd.addr[7:0]] <= mem_cmd.wdata;
        mem_rdata              <= ~mem_rdata;
      end else begin
        mem_rdata <= mem[mem_cmd.addr[7:0]];
      end
    end
  end
endmodule
`default_nettype wire

// ### word_halfword_byte_move_datapath_bench.sv
// Self-checking bench for the word move datapath
`timescale 1ns/1ps
`default_nettype none

module word_halfword_byte_move_datapath_bench
  import move_pkg::*;
();
  logic        core_clk, resetn, start, irq_req; // Clock and controls
  logic        mem_ack, busy, done, blt_int;     // Design handshakes
  logic [1:0]  wait_cycles;                      // Memory wait
  logic [7:0]  res_exp;                          // Result exponent
  logic [35:0] mem_rdata, res;                   // Read data, last result
  logic [35:0] rm [256];                         // Expected memory
  instr_t      instr;                            // Instruction driven
  mem_cmd_t    mem_cmd;                          // Memory command
  int          fails = 0, compares = 0, cyc = 0; // Counters
  integer      seed = 32'hB346FFF3;              // Random seed
  // ********************
  // Clock, design, memory, hang guard
  // ********************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  move_datapath i_dut (.core_clk(core_clk), .resetn(resetn), .start(start),
    .instr(instr), .irq_req(irq_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_cmd(mem_cmd), .busy(busy), .done(done),
    .blt_interrupted(blt_int), .res_exponent(res_exp));
  move_memory_model i_mem (.core_clk(core_clk), .resetn(resetn),
    .mem_cmd(mem_cmd), .wait_cycles(wait_cycles), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      stop_test();
    end
  end
  // ********************
  // Helpers and reference model
  // ********************
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic poke(input int a, input logic [35:0] v);
    rm[a] = v;
    i_mem.mem[a] = v;
  endtask
  function automatic int rnd(input int n);
    return ($random(seed) & 32'h7FFFFFFF) % n;
  endfunction
  // Address plus index, repeated while indirect
  function automatic logic [17:0] ea_of(input logic [22:0] aw);
    logic [17:0] y;
    for (int n = 0; n < 8; n++) begin
      y = aw[17:0] + (aw[21:18] != 4'h0 ? rm[aw[21:18]][17:0] : 18'h0);
      if (!aw[22]) return y;
      aw = rm[y[7:0]][22:0];
    end
    return y;
  endfunction
  function automatic logic [35:0] xf(input xform_t x, input logic [35:0] v);
    case (x)
      XF_HALVES_SWAPPED: return {v[17:0], v[35:18]};
      XF_NEGATED:        return -v;
      XF_MAGNITUDE:      return v[35] ? -v : v;
      default:           return v;
    endcase
  endfunction
  function automatic logic [35:0] hf(input instr_t i, input logic [35:0] s,
                                     input logic [35:0] d);
    logic [17:0] h, o;
    h = i.src_left ? s[35:18] : s[17:0];
    case (i.fill)
      FILL_ZERO: o = 18'h00000;
      FILL_ONES: o = 18'h3FFFF;
      FILL_SIGN: o = {18{h[17]}};
      default:   o = i.dst_left ? d[17:0] : d[35:18];
    endcase
    return i.dst_left ? {h, o} : {o, h};
  endfunction
  function automatic logic [35:0] adv(input logic [35:0] p);
    if (p[35:30] < p[29:24])
      return {6'h24 - p[29:24], p[29:18], p[17:0] + 18'h00001};
    return {p[35:30] - p[29:24], p[29:0]};
  endfunction
  task automatic model(input instr_t i, input logic brk);
    logic [17:0] e, a, sa;
    logic [35:0] m, w, k;
    e = ea_of(i.addr_word);
    a = {14'h0000, i.ac};
    m = rm[e[7:0]];
    w = rm[a[7:0]];
    if (i.op == OP_MOVE || i.op == OP_HALF) begin
      if (i.mode == MD_IMMEDIATE) m = {18'h00000, e};
      k = (i.mode == MD_MEMORY) ? w : m;
      res = (i.op == OP_MOVE) ? xf(i.xform, k) : hf(i, k, i.mode[1] ? m : w);
      if (i.mode[1]) rm[e[7:0]] = res;
      else rm[a[7:0]] = res;
    end else if (i.op == OP_SWAP_AC_MEM) begin
      rm[e[7:0]] = w;
      rm[a[7:0]] = m;
    end else if (i.op == OP_BLOCK_COPY) begin
      sa = w[35:18];
      for (logic [17:0] d = w[17:0]; 1; d++) begin
        rm[d[7:0]] = rm[sa[7:0]];
        if (d == e) break;
        sa++;
        if (brk) begin
          rm[a[7:0]] = {sa, d + 18'h00001};
          break;
        end
      end
    end else begin
      if (i.op >= OP_ADVANCE_PTR) m = adv(m);
      rm[e[7:0]] = m;
      sa = ea_of(m[22:0]);
      k = (m[29:24] > 6'h23) ? '1 : (36'h1 << m[29:24]) - 36'h1;
      if (i.op == OP_LOAD_BYTE || i.op == OP_ADV_LOAD_BYTE)
        rm[a[7:0]] = (rm[sa[7:0]] >> m[35:30]) & k;
      else if (i.op != OP_ADVANCE_PTR)
        rm[sa[7:0]] = rm[sa[7:0]] & ~(k << m[35:30]) | (w & k) << m[35:30];
    end
  endtask
  // Run one instruction, then compare memory, flag and, for moves, exponent
  task automatic go(input op_t o, input logic [3:0] f, input mode_t md,
                    input logic [3:0] ac, input logic [22:0] aw,
                    input logic brk);
    instr_t i;
    i = {o, xform_t'(f[1:0]), md, f[3], f[2], fill_t'(f[1:0]), ac, aw};
    @(posedge core_clk);
    start       <= 1'b1;
    instr       <= i;
    irq_req     <= brk;
    wait_cycles <= 2'(rnd(4));
    @(posedge core_clk);
    start <= 1'b0;
    for (int n = 0; n < 500 && done !== 1'b1; n++) @(negedge core_clk);
    check(36'(done), 36'h1);
    model(i, brk);
    for (int k = 0; k < 256; k++) check(i_mem.mem[k], rm[k]);
    check(36'(blt_int), 36'(brk));
    if (o <= OP_HALF) check(36'(res_exp), 36'(res[34:27]));
  endtask
  // ********************
  // Test sequence
  // ********************
  initial begin
    logic [5:0] s, p;
    resetn      = 1'b0;
    start       = 1'b0;
    irq_req     = 1'b0;
    instr       = '0;
    wait_cycles = 2'h0;
    for (int k = 0; k < 256; k++) poke(k, {4'(rnd(16)), 32'($random(seed))});
    repeat (16) @(posedge core_clk);
    check(36'({mem_cmd.req, busy, done, blt_int, res_exp}), 36'h0);
    resetn <= 1'b1;
    for (int t = 0; t < 128; t++)
      go(t[6] ? OP_HALF : OP_MOVE, 4'(t), mode_t'(t[5:4]),
         4'(1 + rnd(15)), 23'(32 + rnd(64)), 1'b0);
    poke(33, 36'h800000000);
    go(OP_MOVE, 4'h3, MD_BASIC, 4'h2, 23'h21, 1'b0);
    poke(5, 36'h000000010);
    poke(48, 36'h000000050);
    go(OP_MOVE, 4'h0, MD_BASIC, 4'h2, {1'b1, 4'h5, 18'h20}, 1'b0);
    go(OP_HALF, 4'h5, MD_BASIC, 4'h7, 23'h3, 1'b0);
    $display("move tests done");
    for (int t = 0; t < 40; t++) begin
      s = 6'(1 + rnd(36));
      p = 6'(rnd(37 - s));
      if (t[3]) p = p % s;
      poke(64 + t, {p, s, 6'h00, 18'(96 + t)});
      go(op_t'(2 + t % 5), 4'h0, MD_BASIC, 4'(1 + rnd(15)), 23'(64 + t),
         1'b0);
    end
    $display("byte tests done");
    for (int t = 0; t < 4; t++)
      go(OP_SWAP_AC_MEM, 4'h0, MD_BASIC, 4'(1 + t), 23'(140 + t), 1'b0);
    for (int t = 1; t <= 4; t++) begin
      poke(9, {18'(150 + t), 18'h000C8});
      go(OP_BLOCK_COPY, 4'h0, MD_BASIC, 4'h9, 23'(199 + 2 * t), 1'b0);
    end
    poke(9, {18'h000A0, 18'h000D0});
    go(OP_BLOCK_COPY, 4'h0, MD_BASIC, 4'h9, 23'h0D3, 1'b1);
    go(OP_BLOCK_COPY, 4'h0, MD_BASIC, 4'h9, 23'h0D3, 1'b0);
    $display("exchange and block tests done");
    stop_test();
  end
endmodule
`default_nettype wire
